/* File: hw/lan_flow_pkg.sv */
// Package with the constants shared by the LAN flow bridge design.
package lan_flow_pkg;
    // APB register byte offsets.
    localparam logic [7:0] OFF_CONTROL   = 8'h00;
    localparam logic [7:0] OFF_STATUS    = 8'h04;
    localparam logic [7:0] OFF_IRQ_STAT  = 8'h08;
    localparam logic [7:0] OFF_IRQ_MASK  = 8'h0C;
    localparam logic [7:0] OFF_TOTAL     = 8'h10;
    localparam logic [7:0] OFF_ERRORS    = 8'h14;
    localparam logic [7:0] OFF_PER       = 8'h18;
    localparam logic [7:0] OFF_STATS_CLR = 8'h1C;
    localparam logic [7:0] OFF_PORT_STAT = 8'h20;
    // Control register fields.
    localparam int CTL_FLOW_EN  = 0;
    localparam int CTL_DAISY_EN = 1;
    localparam logic [31:0] CONTROL_RESET = 32'h0000_0000;
    localparam logic [31:0] MASK_RESET    = 32'h0000_0000;
    // Interrupt status bit positions.
    localparam int IRQ_DROP     = 0;
    localparam int IRQ_PAUSE    = 1;
    localparam int IRQ_MINOR    = 2;
    localparam int IRQ_MAJOR    = 3;
    localparam int IRQ_RX_ERROR = 4;
    localparam int IRQ_BITS     = 5;
    // Pause quanta values carried by pause frames.
    localparam logic [15:0] PAUSE_MAX  = 16'hFFFF;
    localparam logic [15:0] PAUSE_ZERO = 16'h0000;
    // Free-buffer thresholds in packet slots.
    localparam int LOW_WATER  = 2;
    localparam int HIGH_WATER = 4;
    // Fixed-point scale for the packet error rate, parts per 65536.
    localparam int PER_SHIFT = 16;
    // Link status encoding for each port.
    typedef enum logic [2:0]
    {
        LINK_DOWN       = 3'h0,
        LINK_UNRESOLVED = 3'h1,
        LINK_10_HALF    = 3'h2,
        LINK_10_FULL    = 3'h3,
        LINK_100_HALF   = 3'h4,
        LINK_100_FULL   = 3'h5
    } link_state_t;
    // Forwarding destinations for ingress frames.
    localparam logic [1:0] DEST_SAT  = 2'h0;
    localparam logic [1:0] DEST_LAN  = 2'h1;
    localparam logic [1:0] DEST_DROP = 2'h2;
endpackage

/* File: hw/per_divider.sv */
// Sequential divider that yields the packet error rate as a scaled fraction.
`timescale 1ns/1ps
`default_nettype none
module per_divider #(
    parameter int CW = 32
) (
    input  wire logic          core_clk,
    input  wire logic          rst,
    input  wire logic          start,
    input  wire logic [CW-1:0] numer,
    input  wire logic [CW-1:0] denom,
    output logic               busy,
    output logic [31:0]        quotient
);
    localparam int NW = CW + lan_flow_pkg::PER_SHIFT;
    typedef struct packed
    {
        logic          run;
        logic [7:0]    step;
        logic [NW-1:0] num;
        logic [NW:0]   rem;
        logic [CW-1:0] den;
        logic [NW-1:0] quo;
        logic [31:0]   result;
    } div_state_t;
    div_state_t state;
    div_state_t next_state;
    logic [NW:0] trial;

    // Restoring division, one quotient bit per cycle; slow but small, and the rate only feeds a monitor.
    always_comb
    begin
        next_state = state;
        trial = '0;
        if (!state.run && start)
        begin
            next_state.run  = 1'b1;
            next_state.step = 8'(NW);
            next_state.num  = {numer, {lan_flow_pkg::PER_SHIFT{1'b0}}};
            next_state.den  = denom;
            next_state.rem  = '0;
            next_state.quo  = '0;
        end
        else if (state.run)
        begin
            trial = {state.rem[NW-1:0], state.num[NW-1]};
            next_state.num = {state.num[NW-2:0], 1'b0};
            if (trial >= (NW+1)'(state.den))
            begin
                next_state.rem = trial - (NW+1)'(state.den);
                next_state.quo = {state.quo[NW-2:0], 1'b1};
            end
            else
            begin
                next_state.rem = trial;
                next_state.quo = {state.quo[NW-2:0], 1'b0};
            end
            next_state.step = state.step - 8'h01;
            if (state.step == 8'h01)
            begin
                next_state.run = 1'b0;
                next_state.result = (state.den == '0) ? 32'h0000_0000 : 32'(next_state.quo);
            end
        end
    end

    // State register.
    always_ff @(posedge core_clk)
    begin
        if (rst)
            state <= '0;
        else
            state <= next_state;
    end

    assign busy     = state.run;
    assign quotient = state.result;
endmodule
`default_nettype wire

/* File: hw/ethernet_lan_flow_bridge.sv */
// Ethernet LAN flow bridge: flow control, port-four forwarding, satellite statistics and link alarms.
// Behaviour
// - Flow control off: drop an ingress packet when no buffer slot is free.
// - Half duplex, flow on, buffer nearly full: force collision on sensed packet.
// - Half duplex: stop forcing collisions once free slots reach the high water mark.
// - Full duplex, flow on, buffer nearly full: send pause with maximum time.
// - After a maximum pause, send zero-time pause once space frees.
// - Daisy chain off: port-four traffic not for LAN goes to satellite.
// - Daisy chain on: all port-four traffic goes to LAN ports 1-3 only; the code still drops it when flow control is off and no slot is free.
// - Count every packet received from the satellite; the code skips one that arrives with a statistics clear.
// - Count satellite-received packets that carried errors.
// - Report packet error rate from error and total counts.
// - Statistics reset clears both total and error counters.
// - Each LAN port and WAN reports one of six link states.
// - All LAN ports down raises the minor transmit-activity alarm.
// - WAN down raises the major transmit and receive WAN alarm.
`timescale 1ns/1ps
`default_nettype none
module ethernet_lan_flow_bridge #(
    parameter int LAN_PORTS  = 4,
    parameter int CNT_W      = 32,
    parameter int FREE_W     = 8
) (
    input  wire logic              core_clk,
    input  wire logic              rst,
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [7:0]        paddr,
    input  wire logic [31:0]       pwdata,
    output logic                   pready,
    output logic [31:0]            prdata,
    output logic                   pslverr,
    input  wire logic [FREE_W-1:0] freeSlots,
    input  wire logic              halfDuplex,
    input  wire logic              ingressStart,
    input  wire logic              ingressCarrier,
    input  wire logic              ingressFromPortFour,
    input  wire logic              ingressForLan,
    output logic                   ingressValid,
    output logic [1:0]             ingressDest,
    output logic                   forceCollision,
    output logic                   pauseSend,
    output logic [15:0]            pauseQuanta,
    input  wire logic              pauseDone,
    input  wire logic              satPacket,
    input  wire logic              satPacketError,
    input  wire logic [2:0]        lanLinkState [LAN_PORTS],
    input  wire logic [2:0]        wanLinkState,
    output logic                   minorAlarm,
    output logic                   majorAlarm,
    output logic                   irq
);
    localparam int IRQ_W = lan_flow_pkg::IRQ_BITS;
    typedef struct packed
    {
        logic [31:0]          control;
        logic [IRQ_W-1:0]     irqStat;
        logic [IRQ_W-1:0]     irqMask;
        logic [CNT_W-1:0]     total;
        logic [CNT_W-1:0]     errors;
        logic                 nearFull;
        logic                 collide;
        logic                 paused;
        logic                 pauseReq;
        logic [15:0]          quanta;
        logic                 fwdValid;
        logic [1:0]           fwdDest;
        logic                 minor;
        logic                 major;
        logic [31:0]          rdata;
        logic                 divKick;
    } bridge_state_t;

    bridge_state_t state;
    bridge_state_t next_state;
    logic          apbWrite;
    logic          apbRead;
    logic          flowOn;
    logic          daisyOn;
    logic          noSpace;
    logic          spaceBack;
    logic          allLanDown;
    logic [IRQ_W-1:0] events;
    logic          divBusy;
    logic [31:0]   perValue;
    logic [31:0]   portWord;

    // The divider reruns after every counter change; a kick waits while a run is busy.
    per_divider #(
        .CW (CNT_W)
    ) rateDivider (
        .core_clk (core_clk),
        .rst      (rst),
        .start    (state.divKick),
        .numer    (state.errors),
        .denom    (state.total),
        .busy     (divBusy),
        .quotient (perValue)
    );

    // True for a port whose link is down.
    function automatic logic is_down(input logic [2:0] s);
        return s == 3'(lan_flow_pkg::LINK_DOWN);
    endfunction

    // Zero wait states: the slave never stretches.
    assign apbWrite = psel && penable && pwrite;
    assign apbRead  = psel && penable && !pwrite;
    assign pready   = 1'b1;

    // Control fields and buffer level comparisons.
    assign flowOn    = state.control[lan_flow_pkg::CTL_FLOW_EN];
    assign daisyOn   = state.control[lan_flow_pkg::CTL_DAISY_EN];
    assign noSpace   = (freeSlots == '0);
    assign spaceBack = (freeSlots >= FREE_W'(lan_flow_pkg::HIGH_WATER));

    // Link alarm conditions.
    always_comb
    begin
        allLanDown = 1'b1;
        portWord = 32'h0000_0000;
        for (int i = 0; i < LAN_PORTS; i++)
        begin
            allLanDown = allLanDown && is_down(lanLinkState[i]);
            portWord[3*i +: 3] = lanLinkState[i];
        end
        portWord[3*LAN_PORTS +: 3] = wanLinkState;
    end

    // All next-state logic of the bridge.
    always_comb
    begin
        next_state = state;
        next_state.fwdValid = 1'b0;
        next_state.divKick = state.divKick && divBusy;
        events = '0;

        // Nearly-full flag with hysteresis between low and high water marks.
        if (freeSlots <= FREE_W'(lan_flow_pkg::LOW_WATER))
            next_state.nearFull = 1'b1;
        else if (spaceBack)
            next_state.nearFull = 1'b0;

        // Half duplex backpressure: jam while a carrier is sensed and space is short.
        next_state.collide = flowOn && halfDuplex && next_state.nearFull && ingressCarrier;

        // Full duplex pause generation, one request at a time.
        if (state.pauseReq && pauseDone)
            next_state.pauseReq = 1'b0;
        if (flowOn && !halfDuplex && !state.pauseReq)
        begin
            if (!state.paused && next_state.nearFull)
            begin
                next_state.pauseReq = 1'b1;
                next_state.quanta   = lan_flow_pkg::PAUSE_MAX;
                next_state.paused   = 1'b1;
                events[lan_flow_pkg::IRQ_PAUSE] = 1'b1;
            end
            else if (state.paused && !next_state.nearFull)
            begin
                next_state.pauseReq = 1'b1;
                next_state.quanta   = lan_flow_pkg::PAUSE_ZERO;
                next_state.paused   = 1'b0;
            end
        end
        else if (!flowOn && !state.pauseReq)
            next_state.paused = 1'b0;

        // Ingress forwarding decision, one per packet start.
        if (ingressStart)
        begin
            next_state.fwdValid = 1'b1;
            if (!flowOn && noSpace)
            begin
                next_state.fwdDest = lan_flow_pkg::DEST_DROP;
                events[lan_flow_pkg::IRQ_DROP] = 1'b1;
            end
            else if (ingressFromPortFour && daisyOn)
                next_state.fwdDest = lan_flow_pkg::DEST_LAN;
            else if (ingressForLan)
                next_state.fwdDest = lan_flow_pkg::DEST_LAN;
            else
                next_state.fwdDest = lan_flow_pkg::DEST_SAT;
        end

        // Satellite statistics, with the clear request taking priority over counting.
        if (apbWrite && paddr == lan_flow_pkg::OFF_STATS_CLR && pwdata[0])
        begin
            next_state.total  = '0;
            next_state.errors = '0;
            next_state.divKick = 1'b1;
        end
        else if (satPacket)
        begin
            next_state.total = state.total + CNT_W'(1);
            if (satPacketError)
            begin
                next_state.errors = state.errors + CNT_W'(1);
                events[lan_flow_pkg::IRQ_RX_ERROR] = 1'b1;
            end
            next_state.divKick = 1'b1;
        end

        // Alarms and their rising-edge events.
        next_state.minor = allLanDown;
        next_state.major = is_down(wanLinkState);
        events[lan_flow_pkg::IRQ_MINOR] = allLanDown && !state.minor;
        events[lan_flow_pkg::IRQ_MAJOR] = next_state.major && !state.major;

        // Register writes; a new event wins over a write-one clear in the same cycle.
        if (apbWrite)
        begin
            unique case (paddr)
                lan_flow_pkg::OFF_CONTROL:  next_state.control = {30'h0000_0000, pwdata[1:0]};
                lan_flow_pkg::OFF_IRQ_STAT: next_state.irqStat = state.irqStat & ~pwdata[IRQ_W-1:0];
                lan_flow_pkg::OFF_IRQ_MASK: next_state.irqMask = pwdata[IRQ_W-1:0];
                default: ;
            endcase
        end
        next_state.irqStat = next_state.irqStat | events;

        // Read data is captured in the setup cycle so it stands during the access cycle.
        next_state.rdata = 32'h0000_0000;
        if (psel && !penable && !pwrite)
        begin
            unique case (paddr)
                lan_flow_pkg::OFF_CONTROL:   next_state.rdata = state.control;
                lan_flow_pkg::OFF_STATUS:    next_state.rdata = {25'h0, divBusy || state.divKick, state.paused,
                    state.nearFull, state.collide, state.minor, state.major, halfDuplex};
                lan_flow_pkg::OFF_IRQ_STAT:  next_state.rdata = 32'(state.irqStat);
                lan_flow_pkg::OFF_IRQ_MASK:  next_state.rdata = 32'(state.irqMask);
                lan_flow_pkg::OFF_TOTAL:     next_state.rdata = 32'(state.total);
                lan_flow_pkg::OFF_ERRORS:    next_state.rdata = 32'(state.errors);
                lan_flow_pkg::OFF_PER:       next_state.rdata = perValue;
                lan_flow_pkg::OFF_PORT_STAT: next_state.rdata = portWord;
                default: ;
            endcase
        end
    end

    // Single state register.
    always_ff @(posedge core_clk)
    begin
        if (rst)
        begin
            state <= '0;
            state.control <= lan_flow_pkg::CONTROL_RESET;
            state.irqMask <= IRQ_W'(lan_flow_pkg::MASK_RESET);
        end
        else
            state <= next_state;
    end

    // Unmapped addresses answer with an error and zero data.
    assign pslverr = psel && penable && (paddr > lan_flow_pkg::OFF_PORT_STAT || paddr[1:0] != 2'h0);

    // Outputs straight from the state register.
    assign prdata         = state.rdata;
    assign forceCollision = state.collide;
    assign pauseSend      = state.pauseReq;
    assign pauseQuanta    = state.quanta;
    assign ingressValid   = state.fwdValid;
    assign ingressDest    = state.fwdDest;
    assign minorAlarm     = state.minor;
    assign majorAlarm     = state.major;
    assign irq            = |(state.irqStat & state.irqMask);
endmodule
`default_nettype wire

/* File: verification/pause_sink_model.sv */
// Behavioural model of the MAC that sends pause frames for the bridge.
`timescale 1ns/1ps
`default_nettype none
module pause_sink_model (
    input  wire logic        core_clk,
    input  wire logic        rst,
    input  wire logic        slow,
    input  wire logic        pauseSend,
    input  wire logic [15:0] pauseQuanta,
    output logic             pauseDone,
    output logic [7:0]       pauses,
    output logic [15:0]      lastQuanta
);
    int waitCnt;
    // Each request is answered after two or seven cycles.
    // The cycle after a completion is skipped, because the request still stands then.
    always @(posedge core_clk)
    begin
        pauseDone <= 1'b0;
        if (rst)
        begin
            pauses     <= 8'h00;
            lastQuanta <= 16'h0000;
            waitCnt = 0;
        end
        else if (pauseSend && !pauseDone)
        begin
            waitCnt = waitCnt + 1;
            if (waitCnt > (slow ? 6 : 1))
            begin
                pauseDone  <= 1'b1;
                pauses     <= pauses + 8'h01;
                lastQuanta <= pauseQuanta;
                waitCnt = 0;
            end
        end
    end
endmodule
`default_nettype wire

/* File: verification/ethernet_lan_flow_bridge_properties.sv */
// Concurrent properties watching the LAN flow bridge ports.
`timescale 1ns/1ps
`default_nettype none
module ethernet_lan_flow_bridge_properties #(
    parameter int LAN_PORTS = 4,
    parameter int FREE_W    = 8
) (
    input wire logic              core_clk,
    input wire logic              rst,
    input wire logic [FREE_W-1:0] freeSlots,
    input wire logic              halfDuplex,
    input wire logic              ingressStart,
    input wire logic              ingressCarrier,
    input wire logic              ingressForLan,
    input wire logic              ingressValid,
    input wire logic [1:0]        ingressDest,
    input wire logic              forceCollision,
    input wire logic              pauseSend,
    input wire logic [15:0]       pauseQuanta,
    input wire logic              pauseDone,
    input wire logic [2:0]        lanLinkState [LAN_PORTS],
    input wire logic [2:0]        wanLinkState,
    input wire logic              minorAlarm,
    input wire logic              majorAlarm
);
    logic [1:0] age;
    logic       allDown;
    // Alarms are judged only once their register holds a post-reset sample.
    always_ff @(posedge core_clk)
    begin
        if (rst)
            age <= 2'h0;
        else if (age != 2'h2)
            age <= age + 2'h1;
    end
    // True while every LAN port reports the link as down.
    always_comb
    begin
        allDown = 1'b1;
        for (int i = 0; i < LAN_PORTS; i++)
            allDown &= (lanLinkState[i] == lan_flow_pkg::LINK_DOWN);
    end
    default clocking dcb @(posedge core_clk);
    endclocking
    default disable iff (rst);
    property p_room_no_drop;
        ingressStart && freeSlots != '0 |=> ingressValid && ingressDest != lan_flow_pkg::DEST_DROP;
    endproperty
    a_room_no_drop: assert property (p_room_no_drop) else $error("drop with room");
    property p_lan_dest;
        ingressStart && ingressForLan && freeSlots != '0 |=> ingressDest == lan_flow_pkg::DEST_LAN;
    endproperty
    a_lan_dest: assert property (p_lan_dest) else $error("LAN dest");
    property p_collide_cause;
        forceCollision |-> $past(ingressCarrier) && $past(halfDuplex);
    endproperty
    a_collide_cause: assert property (p_collide_cause) else $error("collision cause");
    property p_collide_stop;
        freeSlots >= lan_flow_pkg::HIGH_WATER |=> !forceCollision;
    endproperty
    a_collide_stop: assert property (p_collide_stop) else $error("collision held");
    property p_quanta;
        pauseSend |-> pauseQuanta == lan_flow_pkg::PAUSE_MAX || pauseQuanta == lan_flow_pkg::PAUSE_ZERO;
    endproperty
    a_quanta: assert property (p_quanta) else $error("pause quanta");
    property p_pause_hold;
        pauseSend && !pauseDone |=> pauseSend && $stable(pauseQuanta);
    endproperty
    a_pause_hold: assert property (p_pause_hold) else $error("pause dropped");
    property p_pause_end;
        $fell(pauseSend) |-> $past(pauseDone) || $past(pauseDone, 2);
    endproperty
    a_pause_end: assert property (p_pause_end) else $error("pause end");
    property p_minor;
        age == 2'h2 && $stable(allDown) |-> minorAlarm == allDown;
    endproperty
    a_minor: assert property (p_minor) else $error("minor alarm");
    property p_major;
        age == 2'h2 && $stable(wanLinkState) |-> majorAlarm == (wanLinkState == lan_flow_pkg::LINK_DOWN);
    endproperty
    a_major: assert property (p_major) else $error("major alarm");
    c_collide: cover property (forceCollision);
    c_zero_pause: cover property (pauseSend && pauseQuanta == lan_flow_pkg::PAUSE_ZERO);
    c_major: cover property (majorAlarm && minorAlarm);
endmodule
bind ethernet_lan_flow_bridge ethernet_lan_flow_bridge_properties #(.LAN_PORTS(LAN_PORTS), .FREE_W(FREE_W)) u_props (
    .core_clk(core_clk), .rst(rst), .freeSlots(freeSlots), .halfDuplex(halfDuplex),
    .ingressStart(ingressStart), .ingressCarrier(ingressCarrier), .ingressForLan(ingressForLan),
    .ingressValid(ingressValid), .ingressDest(ingressDest), .forceCollision(forceCollision),
    .pauseSend(pauseSend), .pauseQuanta(pauseQuanta), .pauseDone(pauseDone), .lanLinkState(lanLinkState),
    .wanLinkState(wanLinkState), .minorAlarm(minorAlarm), .majorAlarm(majorAlarm));
`default_nettype wire

/* File: verification/ethernet_lan_flow_bridge_tb.sv */
// Self-checking testbench for the LAN flow bridge.
`timescale 1ns/1ps
`default_nettype none
module ethernet_lan_flow_bridge_tb;
    logic        core_clk = 0, rst = 1, psel = 0, penable = 0, pwrite = 0, pready, pslverr, err, slow = 0;
    logic        halfDuplex = 0, ingressStart = 0, ingressCarrier = 0, ingressFromPortFour = 0, ingressForLan = 0;
    logic        satPacket = 0, satPacketError = 0, ingressValid, forceCollision, pauseSend, pauseDone;
    logic        minorAlarm, majorAlarm, irq;
    logic [7:0]  paddr = 0, freeSlots = 8'h08, pauses;
    logic [31:0] pwdata = 0, prdata, q;
    logic [1:0]  ingressDest;
    logic [15:0] pauseQuanta, lastQuanta;
    logic [2:0]  lanLinkState [4] = '{default: 3'h5};
    logic [2:0]  wanLinkState = 3'h5;
    int          n_fail = 0, total_checks = 0;
    ethernet_lan_flow_bridge uut (.core_clk(core_clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr), .freeSlots(freeSlots),
        .halfDuplex(halfDuplex), .ingressStart(ingressStart), .ingressCarrier(ingressCarrier),
        .ingressFromPortFour(ingressFromPortFour), .ingressForLan(ingressForLan), .ingressValid(ingressValid),
        .ingressDest(ingressDest), .forceCollision(forceCollision), .pauseSend(pauseSend), .pauseQuanta(pauseQuanta),
        .pauseDone(pauseDone), .satPacket(satPacket), .satPacketError(satPacketError), .lanLinkState(lanLinkState),
        .wanLinkState(wanLinkState), .minorAlarm(minorAlarm), .majorAlarm(majorAlarm), .irq(irq));
    pause_sink_model mac (.core_clk(core_clk), .rst(rst), .slow(slow), .pauseSend(pauseSend),
        .pauseQuanta(pauseQuanta), .pauseDone(pauseDone), .pauses(pauses), .lastQuanta(lastQuanta));
    // Free-running clock at 100 MHz.
    always #5 core_clk = ~core_clk;
    task chk(input string n, input logic [31:0] e, input logic [31:0] g);
        total_checks++;
        if (g !== e)
        begin
            n_fail++;
            $display("BAD %s expected %h seen %h", n, e, g);
        end
    endtask
    // One APB transfer; the reply is taken at the edge that sees pready.
    task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge core_clk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge core_clk);
        penable <= 1'b1;
        do
        begin
            @(posedge core_clk);
            n++;
        end
        while (pready !== 1'b1 && n < 20);
        q = prdata;
        err = pslverr;
        n_fail += (pready !== 1'b1);
        psel <= 1'b0;
        penable <= 1'b0;
        #1;
    endtask
    task ingress(input logic p4, input logic lan, input logic [1:0] d);
        @(posedge core_clk);
        ingressStart <= 1'b1;
        ingressFromPortFour <= p4;
        ingressForLan <= lan;
        @(posedge core_clk);
        ingressStart <= 1'b0;
        #1;
        chk("ingressValid", 1, ingressValid);
        chk("ingressDest", d, ingressDest);
    endtask
    task waitp(input int n);
        for (int k = 0; pauses !== 8'(n) && k < 200; k++)
            @(posedge core_clk);
        #1;
    endtask
    // Reset values, unmapped access, drop with flow off and the interrupt path.
    task t_drop_irq;
        apb(0, lan_flow_pkg::OFF_CONTROL, 0);
        chk("control", lan_flow_pkg::CONTROL_RESET, q);
        apb(0, lan_flow_pkg::OFF_IRQ_MASK, 0);
        chk("mask", lan_flow_pkg::MASK_RESET, q);
        apb(0, 8'h24, 0);
        chk("unmapped err", 1, err);
        chk("unmapped data", 0, q);
        @(posedge core_clk);
        freeSlots <= 8'h00;
        ingress(0, 0, lan_flow_pkg::DEST_DROP);
        chk("irq masked", 0, irq);
        apb(1, lan_flow_pkg::OFF_IRQ_MASK, 32'h0000_0001);
        chk("irq on", 1, irq);
        apb(1, lan_flow_pkg::OFF_IRQ_STAT, 32'h0000_0001);
        chk("irq cleared", 0, irq);
    endtask
    // Port-four forwarding with the chain off and on.
    task t_forward;
        @(posedge core_clk);
        freeSlots <= 8'h08;
        ingress(1, 0, lan_flow_pkg::DEST_SAT);
        ingress(0, 1, lan_flow_pkg::DEST_LAN);
        apb(1, lan_flow_pkg::OFF_CONTROL, 32'h0000_0002);
        ingress(1, 0, lan_flow_pkg::DEST_LAN);
        ingress(1, 1, lan_flow_pkg::DEST_LAN);
    endtask
    // Backpressure: enters at two free slots, holds at three, ends at four.
    task t_collide;
        apb(1, lan_flow_pkg::OFF_CONTROL, 32'h0000_0001);
        @(posedge core_clk);
        halfDuplex <= 1'b1;
        ingressCarrier <= 1'b1;
        freeSlots <= 8'h02;
        repeat (3) @(posedge core_clk);
        freeSlots <= 8'h03;
        #1;
        chk("collide on", 1, forceCollision);
        repeat (3) @(posedge core_clk);
        freeSlots <= 8'h04;
        #1;
        chk("collide held", 1, forceCollision);
        @(posedge core_clk);
        halfDuplex <= 1'b0;
        ingressCarrier <= 1'b0;
        #1;
        chk("collide off", 0, forceCollision);
    endtask
    // Pause rounds, first with a slow then with a prompt MAC.
    task t_pause;
        for (int i = 0; i < 2; i++)
        begin
            @(posedge core_clk);
            slow <= (i == 0);
            freeSlots <= 8'h01;
            waitp(2 * i + 1);
            chk("max pause", lan_flow_pkg::PAUSE_MAX, lastQuanta);
            @(posedge core_clk);
            freeSlots <= 8'h08;
            waitp(2 * i + 2);
            chk("zero pause", lan_flow_pkg::PAUSE_ZERO, lastQuanta);
        end
    endtask
    // Satellite counters, error rate and their clearing.
    task t_stats;
        int k;
        for (int i = 0; i < 3; i++)
        begin
            @(posedge core_clk);
            satPacket <= 1'b1;
            satPacketError <= (i == 1);
            @(posedge core_clk);
            satPacket <= 1'b0;
            satPacketError <= 1'b0;
        end
        apb(0, lan_flow_pkg::OFF_TOTAL, 0);
        chk("total", 3, q);
        apb(0, lan_flow_pkg::OFF_ERRORS, 0);
        chk("errors", 1, q);
        k = 0;
        do
            apb(0, lan_flow_pkg::OFF_STATUS, 0);
        while (q[6] !== 1'b0 && ++k < 60);
        apb(0, lan_flow_pkg::OFF_PER, 0);
        chk("error rate", 32'h0000_5555, q);
        apb(1, lan_flow_pkg::OFF_STATS_CLR, 32'h0000_0001);
        apb(0, lan_flow_pkg::OFF_TOTAL, 0);
        chk("total cleared", 0, q);
        apb(0, lan_flow_pkg::OFF_ERRORS, 0);
        chk("errors cleared", 0, q);
    endtask
    // Link states of every code and the two alarms.
    task t_links;
        @(posedge core_clk);
        lanLinkState <= '{3'h1, 3'h2, 3'h3, 3'h4};
        apb(0, lan_flow_pkg::OFF_PORT_STAT, 0);
        chk("port states", 32'h0000_58D1, q);
        @(posedge core_clk);
        lanLinkState <= '{default: 3'h0};
        repeat (3) @(posedge core_clk);
        wanLinkState <= 3'h0;
        #1;
        chk("minor", 1, minorAlarm);
        repeat (3) @(posedge core_clk);
        #1;
        chk("major", 1, majorAlarm);
        apb(0, lan_flow_pkg::OFF_IRQ_STAT, 0);
        chk("alarm events", 32'h0000_000C, q & 32'h0000_000C);
        apb(0, lan_flow_pkg::OFF_PORT_STAT, 0);
        chk("all down", 0, q);
    endtask
    task finish_test;
        $display("checks %0d mismatches %0d", total_checks, n_fail);
        if (n_fail == 0 && total_checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    // Main sequence after two cycles of reset.
    initial
    begin
        repeat (2) @(posedge core_clk);
        rst <= 1'b0;
        t_drop_irq;
        t_forward;
        t_collide;
        t_pause;
        t_stats;
        t_links;
        finish_test;
    end
    // Watchdog, far beyond the run's length.
    initial
    begin
        repeat (20000) @(posedge core_clk);
        n_fail++;
        finish_test;
    end
endmodule
`default_nettype wire
